// ===== fwsr_pkg.sv
// Package with status bit positions, register map and timing counts for the flash status poller
//
// Contract
// - Host paces status reads with output strobe or chip select.
// - Host reads full data bus twice and compares toggle bits.
// - Unchanged toggle bit means done; next read returns array data.
// - Toggling persists: check timeout bit, recheck, failure means reset command.
// - Host returning from other work restarts polling from first double read.
// - After timeout failure host issues reset command to return to read.
// - Host with under 50 us between added commands need not watch window.
// - Host checks erase window bit before and after each extra sector command.
// - Status reads go to the programmed address or an erasing sector.
package fwsr_pkg;
   // Status bit positions on the data bus
   localparam int POS_ERASE_TOGGLE = 2;
   localparam int POS_WINDOW       = 3;
   localparam int POS_TIMEOUT      = 5;
   localparam int POS_BUSY_TOGGLE  = 6;
   localparam int POS_POLLING      = 7;
   // Register map of the controller (word index, byte address = 4 * index)
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_ADDR   = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;
   localparam logic [3:0] REG_LAST   = 4'h3;
   localparam logic [3:0] REG_LIMIT  = 4'h4;
   // Control bits
   localparam int CTRL_START = 0;
   localparam int CTRL_ABORT = 1;
   localparam int CTRL_ERASE = 2;
   // Status bits
   localparam int ST_BUSY    = 0;
   localparam int ST_DONE    = 1;
   localparam int ST_FAIL    = 2;
   localparam int ST_RESETOK = 3;
   localparam int ST_WINDOW  = 4;
   localparam int ST_ESTOG   = 5;
   // Bus timing: read cycle in ns and its cycle count (rounded up)
   localparam int  CLK_PERIOD_NS = 8;
   localparam int  T_READ_NS     = 70;
   localparam int  READ_CYC      = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  T_REC_NS      = 30;
   localparam int  REC_CYC       = (T_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Reset command word written to the bank
   localparam logic [15:0] CMD_RESET = 16'h00F0;
   localparam logic [15:0] LIMIT_RST = 16'h0100;
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_RD1   = 7'h02,
      ST_RD2   = 7'h04,
      ST_EVAL  = 7'h08,
      ST_RESET = 7'h10,
      ST_FINAL = 7'h20,
      ST_WAIT  = 7'h40
   } fwsr_state_e;
endpackage

// ===== fwsr_poller.sv
// Host-side toggle polling controller for a parallel flash bank
`timescale 1ns/1ps
`default_nettype none
module fwsr_poller
   import fwsr_pkg::*;
#(
   parameter int ADDR_W = 22
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic [3:0]        sw_addr,
   input  wire logic [31:0]       sw_wdata,
   input  wire logic              sw_wr,
   input  wire logic              sw_rd,
   output logic      [31:0]       sw_rdata,
   output logic      [ADDR_W-1:0] flash_addr,
   input  wire logic [15:0]       data_bus_in,
   output logic      [15:0]       data_bus_out,
   output logic                   data_bus_oe,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   input  wire logic              ready_busy_n
);

   fwsr_state_e        state_reg;
   logic [ADDR_W-1:0]  addr_reg;
   logic               erase_mode_reg;
   logic [15:0]        first_reg;
   logic [15:0]        last_reg;
   logic [15:0]        limit_reg;
   logic [15:0]        rounds_reg;
   logic [7:0]         cyc_reg;
   logic               busy_reg;
   logic               done_reg;
   logic               fail_reg;
   logic               resetok_reg;
   logic               seen_to_reg;
   logic [15:0]        d_s1_reg;
   logic [15:0]        d_s2_reg;
   logic               rb_s1_reg;
   logic               rb_s2_reg;
   logic               ctl_start;
   logic               ctl_abort;
   logic               toggling;
   logic               abort_reg;

   // Two-stage synchronisers for pins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         d_s1_reg  <= 16'h0000;
         d_s2_reg  <= 16'h0000;
         rb_s1_reg <= 1'b1;
         rb_s2_reg <= 1'b1;
      end else begin
         d_s1_reg  <= data_bus_in;
         d_s2_reg  <= d_s1_reg;
         rb_s1_reg <= ready_busy_n;
         rb_s2_reg <= rb_s1_reg;
      end
   end

   assign ctl_start = sw_wr && (sw_addr == REG_CTRL) && sw_wdata[CTRL_START];
   assign ctl_abort = sw_wr && (sw_addr == REG_CTRL) && sw_wdata[CTRL_ABORT];
   // Compare toggle bits of two consecutive full-bus reads
   assign toggling = (first_reg[POS_BUSY_TOGGLE] != last_reg[POS_BUSY_TOGGLE])
      || (erase_mode_reg
          && (first_reg[POS_ERASE_TOGGLE] != last_reg[POS_ERASE_TOGGLE]));

   // Software-written configuration
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_reg       <= '0;
         erase_mode_reg <= 1'b0;
         limit_reg      <= LIMIT_RST;
      end else if (sw_wr) begin
         if (sw_addr == REG_ADDR) begin
            addr_reg <= sw_wdata[ADDR_W-1:0];
         end else if (sw_addr == REG_LIMIT) begin
            limit_reg <= sw_wdata[15:0];
         end else if (sw_addr == REG_CTRL && state_reg == ST_IDLE) begin
            erase_mode_reg <= sw_wdata[CTRL_ERASE];
         end
      end
   end

   // Abort request held until the sequencer is back in idle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         abort_reg <= 1'b0;
      end else if (ctl_abort) begin
         abort_reg <= 1'b1;
      end else if (state_reg == ST_IDLE) begin
         abort_reg <= 1'b0;
      end
   end

   // Cycle timer for each bus cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cyc_reg <= 8'h00;
      end else if (state_reg == ST_IDLE || state_reg == ST_EVAL) begin
         cyc_reg <= 8'h00;
      end else if (cyc_reg == 8'(READ_CYC + REC_CYC + 2)) begin
         cyc_reg <= 8'h00;
      end else begin
         cyc_reg <= cyc_reg + 8'h01;
      end
   end

   // Polling sequencer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg   <= ST_IDLE;
         first_reg   <= 16'h0000;
         last_reg    <= 16'h0000;
         rounds_reg  <= 16'h0000;
         seen_to_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (ctl_start) begin
                  state_reg   <= ST_RD1;
                  rounds_reg  <= 16'h0000;
                  seen_to_reg <= 1'b0;
               end
            end
            ST_RD1: begin
               if (cyc_reg == 8'(READ_CYC + 2)) begin
                  first_reg <= d_s2_reg;
               end
               if (cyc_reg == 8'(READ_CYC + REC_CYC + 2)) begin
                  state_reg <= abort_reg ? ST_IDLE : ST_RD2;
               end
            end
            ST_RD2: begin
               if (cyc_reg == 8'(READ_CYC + 2)) begin
                  last_reg <= d_s2_reg; // Last strobe cycle, before release
               end
               if (cyc_reg == 8'(READ_CYC + REC_CYC + 2)) begin
                  state_reg <= ST_EVAL;
               end
            end
            ST_EVAL: begin
               rounds_reg <= rounds_reg + 16'h0001;
               if (!toggling) begin
                  state_reg <= ST_FINAL;
               end else if (seen_to_reg) begin
                  state_reg <= ST_RESET;
               end else if (last_reg[POS_TIMEOUT]) begin
                  seen_to_reg <= 1'b1;
                  first_reg   <= last_reg;
                  state_reg   <= ST_RD2;
               end else if (abort_reg || rounds_reg == limit_reg) begin
                  state_reg <= ST_IDLE;
               end else begin
                  first_reg <= last_reg;
                  state_reg <= ST_RD2;
               end
            end
            ST_RESET: begin
               if (cyc_reg == 8'(READ_CYC + REC_CYC + 2)) begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_FINAL: begin
               if (cyc_reg == 8'(READ_CYC + 2)) begin
                  last_reg <= d_s2_reg;
               end
               if (cyc_reg == 8'(READ_CYC + REC_CYC + 2)) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Busy and outcome flags; done, fail and reset flags cleared by a new start
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_reg    <= 1'b0;
         done_reg    <= 1'b0;
         fail_reg    <= 1'b0;
         resetok_reg <= 1'b0;
      end else begin
         busy_reg <= (state_reg != ST_IDLE) || ctl_start;
         if (state_reg == ST_FINAL && cyc_reg == 8'(READ_CYC + REC_CYC + 2)) begin
            done_reg <= 1'b1;
         end else if (ctl_start && state_reg == ST_IDLE) begin
            done_reg <= 1'b0;
         end
         if (state_reg == ST_EVAL && toggling && seen_to_reg) begin
            fail_reg <= 1'b1;
         end else if (ctl_start && state_reg == ST_IDLE) begin
            fail_reg <= 1'b0;
         end
         if (state_reg == ST_RESET && cyc_reg == 8'(READ_CYC + REC_CYC + 2)) begin
            resetok_reg <= 1'b1;
         end else if (ctl_start && state_reg == ST_IDLE) begin
            resetok_reg <= 1'b0;
         end
      end
   end

   // Flash pin drive: reads pace with output strobe under chip select
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flash_addr   <= '0;
         flash_ce_n   <= 1'b1;
         flash_oe_n   <= 1'b1;
         flash_we_n   <= 1'b1;
         data_bus_out <= 16'h0000;
         data_bus_oe  <= 1'b0;
      end else begin
         flash_addr <= addr_reg;
         if ((state_reg == ST_RD1 || state_reg == ST_RD2 || state_reg == ST_FINAL)
             && cyc_reg < 8'(READ_CYC)) begin
            flash_ce_n <= 1'b0;
            flash_oe_n <= 1'b0;
         end else if (state_reg == ST_RESET && cyc_reg < 8'(READ_CYC)) begin
            flash_ce_n <= 1'b0;
            flash_oe_n <= 1'b1;
         end else begin
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
         end
         flash_we_n   <= !(state_reg == ST_RESET && cyc_reg < 8'(READ_CYC));
         data_bus_out <= CMD_RESET;
         data_bus_oe  <= state_reg == ST_RESET && cyc_reg < 8'(READ_CYC + 1);
      end
   end

   // Register read port, data one cycle after the strobe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_rdata <= 32'h0000_0000;
      end else if (sw_rd) begin
         if (sw_addr == REG_CTRL) begin
            sw_rdata <= {29'h0, erase_mode_reg, 2'b00};
         end else if (sw_addr == REG_ADDR) begin
            sw_rdata <= 32'(addr_reg);
         end else if (sw_addr == REG_STATUS) begin
            sw_rdata <= {26'h0, last_reg[POS_ERASE_TOGGLE], last_reg[POS_WINDOW],
                         resetok_reg, fail_reg, done_reg, busy_reg};
         end else if (sw_addr == REG_LAST) begin
            sw_rdata <= {15'h0, rb_s2_reg, last_reg};
         end else if (sw_addr == REG_LIMIT) begin
            sw_rdata <= {16'h0, limit_reg};
         end else begin
            sw_rdata <= 32'h0000_0000;
         end
      end else begin
         sw_rdata <= 32'h0000_0000;
      end
   end

   // Checks
   property p_oe_only_on_reset;
      @(posedge clk) disable iff (!rst_b)
         data_bus_oe |-> $past(state_reg) == ST_RESET;
   endproperty
   a_oe_only_on_reset: assert property (p_oe_only_on_reset) else $error("stray bus drive");

   property p_fail_leads_reset;
      @(posedge clk) disable iff (!rst_b)
         (state_reg == ST_EVAL && toggling && seen_to_reg) |=> state_reg == ST_RESET;
   endproperty
   a_fail_leads_reset: assert property (p_fail_leads_reset) else $error("no reset command");

   property p_still_done;
      @(posedge clk) disable iff (!rst_b)
         (state_reg == ST_EVAL && !toggling) |=> state_reg == ST_FINAL;
   endproperty
   a_still_done: assert property (p_still_done) else $error("done not taken");

   property p_restart;
      @(posedge clk) disable iff (!rst_b)
         (state_reg == ST_IDLE && ctl_start) |=> state_reg == ST_RD1;
   endproperty
   a_restart: assert property (p_restart) else $error("poll not restarted");

   property p_read_strobe;
      @(posedge clk) disable iff (!rst_b)
         !flash_oe_n |-> !flash_ce_n && flash_we_n && !data_bus_oe;
   endproperty
   a_read_strobe: assert property (p_read_strobe) else $error("bad read strobe");

   property p_timeout_recheck;
      @(posedge clk) disable iff (!rst_b)
         (state_reg == ST_EVAL && toggling && !seen_to_reg && last_reg[POS_TIMEOUT])
         |=> state_reg == ST_RD2 && seen_to_reg;
   endproperty
   a_timeout_recheck: assert property (p_timeout_recheck) else $error("no recheck");

   property p_sample_in_strobe;
      @(posedge clk) disable iff (!rst_b)
         ((state_reg == ST_RD1 || state_reg == ST_RD2 || state_reg == ST_FINAL)
          && cyc_reg == 8'(READ_CYC + 2)) |-> !$past(flash_oe_n, 2);
   endproperty
   a_sample_in_strobe: assert property (p_sample_in_strobe) else $error("late sample");

   property p_limit_stop;
      @(posedge clk) disable iff (!rst_b)
         (state_reg == ST_EVAL && toggling && !seen_to_reg && !last_reg[POS_TIMEOUT]
          && rounds_reg == limit_reg) |=> state_reg == ST_IDLE;
   endproperty
   a_limit_stop: assert property (p_limit_stop) else $error("limit not kept");

   property p_reset_word;
      @(posedge clk) disable iff (!rst_b)
         !flash_we_n |-> data_bus_oe && data_bus_out == CMD_RESET && !flash_ce_n && flash_oe_n;
   endproperty
   a_reset_word: assert property (p_reset_word) else $error("bad reset command");

   c_done:  cover property (@(posedge clk) disable iff (!rst_b) $rose(done_reg));
   c_fail:  cover property (@(posedge clk) disable iff (!rst_b) $rose(fail_reg));
   c_reset: cover property (@(posedge clk) disable iff (!rst_b) $rose(resetok_reg));
endmodule
`default_nettype wire

// ===== fwsr_flash_model.sv
// Behavioural flash bank model that answers status reads of the poller
`timescale 1ns/1ps
`default_nettype none
module fwsr_flash_model
   import fwsr_pkg::*;
#(
   parameter int          ADDR_W     = 22,
   parameter logic [15:0] ARRAY_WORD = 16'h5A3C,
   parameter logic [15:0] ADD_SECTOR = 16'h0001 // Added sector command, value arbitrary
) (
   input  wire logic [ADDR_W-1:0] flash_addr,
   input  wire logic [15:0]       bus,
   input  wire logic              flash_ce_n,
   input  wire logic              flash_oe_n,
   input  wire logic              flash_we_n,
   input  wire logic              go,
   input  wire logic              cfg_erase,
   input  wire logic              cfg_fail,
   input  wire logic [15:0]       cfg_reads,
   input  wire logic [1:0]        cfg_bank,
   output logic      [15:0]       dq,
   output logic                   ready_busy_n,
   output logic                   got_reset
);
   logic        busy, tout, tog6, tog2, win, rd_act, wr_act, hit;
   logic [15:0] left, word, last_q, bus_q;
   initial begin
      {busy, tout, tog6, tog2, win, got_reset} = 6'h00;
      {left, last_q, bus_q} = 48'h0;
   end
   assign rd_act = !flash_ce_n && !flash_oe_n;
   assign wr_act = !flash_ce_n && !flash_we_n;
   assign hit = busy && (flash_addr[ADDR_W-1 -: 2] == cfg_bank);
   // Status word for the busy bank, array data elsewhere
   always_comb begin
      word = ARRAY_WORD;
      if (hit) begin
         word = 16'h0000;
         word[POS_POLLING] = cfg_erase ? 1'b0 : !ARRAY_WORD[7];
         word[POS_BUSY_TOGGLE] = tog6;
         word[POS_TIMEOUT] = tout;
         word[POS_WINDOW] = cfg_erase && win;
         word[POS_ERASE_TOGGLE] = cfg_erase && tog2;
      end
   end
   // Released bus shows the inverse of the last word, no pull-up
   assign dq = rd_act ? word : ~last_q;
   assign ready_busy_n = !busy;
   // New operation, status valid at once
   always @(posedge go) begin
      busy = 1'b1;
      tout = 1'b0;
      win = 1'b0;
      left = cfg_reads;
      got_reset = 1'b0;
   end
   // End of a read strobe, by output enable or chip select
   always @(negedge rd_act) begin
      last_q = word;
      if (hit) begin
         tog6 = !tog6;
         tog2 = !tog2;
         win = 1'b1;
         if (left != 16'h0000) left = left - 16'h0001;
         else if (cfg_fail) tout = 1'b1;
         else busy = 1'b0;
      end
   end
   // Command word latched while the write strobe is low
   always @(bus or wr_act) begin
      if (wr_act) bus_q = bus;
   end
   // Reset command ends a failed operation
   always @(negedge wr_act) begin
      if (bus_q == CMD_RESET) begin
         busy = 1'b0;
         tout = 1'b0;
         got_reset = 1'b1;
      end else if (bus_q == ADD_SECTOR && busy && cfg_erase && !win) begin
         left = cfg_reads;
      end
   end
endmodule
`default_nettype wire

// ===== flash_write_status_reporting_bench.sv
// Self-checking bench of the flash status poller against a behavioural bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("ERROR %0t: value %0h expected %0h", $time, (got), (exp)); \
      end \
   end
module flash_write_status_reporting_bench;
   import fwsr_pkg::*;
   typedef struct {logic erase; logic fail; logic [15:0] reads; logic [1:0] bank;
                   logic done;} fwsr_row_s;
   logic        clk, rst_b, sw_wr, sw_rd, data_bus_oe, ce_n, oe_n, we_n, rb_n;
   logic        go, cfg_erase, cfg_fail, got_reset;
   logic [3:0]  sw_addr;
   logic [31:0] sw_wdata, sw_rdata;
   logic [21:0] flash_addr;
   logic [15:0] data_bus_out, dev_dq, data_bus, cfg_reads;
   int          tests_run, bad_count;
   fwsr_row_s   rows [5] = '{'{0, 0, 3, 1, 1}, '{1, 0, 5, 1, 1}, '{0, 1, 2, 1, 0},
                             '{1, 1, 4, 1, 0}, '{0, 0, 3, 2, 1}};
   // Wire level: host drives only during the reset command
   assign data_bus = data_bus_oe ? data_bus_out : dev_dq;
   fwsr_poller #(.ADDR_W(22)) u_fwsr_poller (.clk(clk), .rst_b(rst_b), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
      .flash_addr(flash_addr), .data_bus_in(data_bus), .data_bus_out(data_bus_out),
      .data_bus_oe(data_bus_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .ready_busy_n(rb_n));
   fwsr_flash_model #(.ADDR_W(22)) u_fwsr_flash_model (.flash_addr(flash_addr),
      .bus(data_bus), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .go(go),
      .cfg_erase(cfg_erase), .cfg_fail(cfg_fail), .cfg_reads(cfg_reads), .cfg_bank(2'h1),
      .dq(dev_dq), .ready_busy_n(rb_n), .got_reset(got_reset));
   // Clock at 125 MHz
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic wrap_up;
      $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1;
      d = sw_rdata;
   endtask
   task automatic wait_idle(output logic [31:0] s);
      int n;
      n = 0;
      rd(REG_STATUS, s);
      while (s[ST_BUSY] !== 1'b0 && n < 2000) begin
         rd(REG_STATUS, s);
         n++;
      end
      if (n >= 2000) begin
         bad_count++;
         $display("ERROR %0t: poller stayed busy", $time);
      end
   endtask
   // Arm the bank model, then start the poller
   task automatic run_op(input logic e, input logic f, input logic [15:0] r,
                         input logic [1:0] b);
      @(posedge clk);
      cfg_erase <= e;
      cfg_fail <= f;
      cfg_reads <= r;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wr(REG_ADDR, 32'(b) << 20);
      wr(REG_CTRL, (32'(e) << CTRL_ERASE) | (32'h1 << CTRL_START));
   endtask
   // Watchdog
   initial begin
      #400000;
      bad_count++;
      $display("ERROR %0t: watchdog expired", $time);
      wrap_up;
   end
   initial begin
      logic [31:0] s, v;
      {sw_addr, sw_wdata, sw_wr, sw_rd, go, cfg_erase, cfg_fail, cfg_reads} = '0;
      {tests_run, bad_count, rst_b} = '0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      foreach (rows[i]) begin
         run_op(rows[i].erase, rows[i].fail, rows[i].reads, rows[i].bank);
         wait_idle(s);
         `CHK(s[ST_DONE], rows[i].done)
         `CHK(s[ST_FAIL], rows[i].fail)
         `CHK(s[ST_RESETOK], rows[i].fail)
         `CHK(got_reset, rows[i].fail)
         rd(REG_LAST, v);
         if (rows[i].done) `CHK(v[15:0], 16'h5A3C)
      end
      // Abort mid-poll while the bank stays busy
      run_op(1'b0, 1'b0, 16'hFFFF, 2'h1);
      repeat (40) @(posedge clk);
      wr(REG_CTRL, 32'h1 << CTRL_ABORT);
      wait_idle(s);
      `CHK(s[ST_DONE], 1'b0)
      rd(REG_LAST, v);
      `CHK(v[16], 1'b0)
      // Round limit runs out
      wr(REG_LIMIT, 32'h3);
      run_op(1'b1, 1'b0, 16'hFFFF, 2'h1);
      wait_idle(s);
      `CHK(s[ST_DONE], 1'b0)
      `CHK(s[ST_FAIL], 1'b0)
      // Unmapped place reads zero and ignores writes
      wr(4'hF, 32'hFFFF_FFFF);
      rd(4'hF, v);
      `CHK(v, 32'h0000_0000)
      // Second reset restores defaults
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rd(REG_LIMIT, v);
      `CHK(v[15:0], LIMIT_RST)
      rd(REG_STATUS, v);
      `CHK(v[2:0], 3'h0)
      wrap_up;
   end
endmodule
`default_nettype wire
